// [core/dit_top.sv]
module dit_top
    import dit_pkg::*;
(
    input  wire logic        core_clk,        // Core clock
    input  wire logic        rst_n,           // Async reset, low
    input  wire logic        fetch_valid,     // Fetch word or pair present
    input  wire logic [31:0] fetch_addr,      // Address of fetched word
    input  wire logic [31:0] fetch_lo,        // Low word, single word
    input  wire logic [31:0] fetch_hi,        // High word, core half
    input  wire logic        core_delayed_br, // Core half is a delayed branch
    input  wire logic        core_sets_cc,    // Core half writes condition
    input  wire logic        core_cc_val,     // Core condition value
    input  wire logic        fp_cmp_cc,       // Float half is a cc compare
    input  wire logic        fp_cmp_val,      // Compare result
    input  wire logic        core_fp_load,    // Core half loads float reg
    input  wire logic        core_fp_store,   // Core half stores float reg
    input  wire logic [4:0]  core_store_reg,  // Stored float register
    input  wire logic        fp_pipelined,    // Float half is pipelined
    input  wire logic [4:0]  fp_pipe_dest,    // Its destination register
    input  wire logic        trap_valid,      // Trap condition, one cycle
    input  wire logic [6:0]  trap_cause,      // Trap condition bits
    input  wire logic        trap_is_sw,      // Caused by trap instruction
    input  wire logic        trap_wait_fp,    // Overflow or listed instr trap
    input  wire logic        fp_done,         // Float companion finished
    input  wire logic [3:0]  reg_addr,        // Register byte address
    input  wire logic [31:0] reg_wdata,       // Register write data
    input  wire logic        reg_we,          // Write strobe
    input  wire logic        reg_re,          // Read strobe
    output logic [31:0]      reg_rdata,       // Read data, next cycle
    output logic             iss_fp_valid,    // Float half to pipelines
    output logic [31:0]      iss_fp_word,     // Float half word
    output logic             iss_core_valid,  // Core instruction valid
    output logic [31:0]      iss_core_word,   // Core instruction word
    output logic             iss_dual,        // Issued as a pair
    output logic             br_cc,           // Condition seen by branch
    output logic             fp_src_old,      // Float reads pre-load value
    output logic             st_fwd_sel,      // Store takes companion result
    output logic             fp_abort,        // Kill float half, pulse
    output logic             fp_finish_req,   // Let float half finish
    output logic             insn_abort,      // Abort current instr, pulse
    output logic             redirect_valid,  // Jump to handler, pulse
    output logic [31:0]      redirect_pc      // Handler address
);
    dit_mode_t   mode;
    logic        next_other;
    logic        dual;
    logic        adv;
    logic        enter_trap;
    logic        fp_kill;
    logic [31:0] core_sel;
    logic        cc_next;
    logic [10:0] psr_reg;
    logic [10:0] psr_next;
    logic [10:0] psr_wr;
    logic [1:0]  ext_reg;
    logic [1:0]  ext_next;
    logic [31:0] fir_reg;
    logic [31:0] fir_next;
    logic        cc_reg;
    logic [31:0] last_addr_reg;
    logic        last_dual_reg;
    logic        last_fnop_reg;
    logic        wait_reg;
    logic [6:0]  wait_cause_reg;
    logic [6:0]  cause_now;
    logic [6:0]  cause_eff;
    logic        sw_now;
    logic [31:0] rd_mux;

    assign dual = (mode == DIT_DUAL) || (mode == DIT_LEAVE);
    // Issue freezes while a trap is entered or waits on the float half
    assign adv = fetch_valid && !trap_valid && !wait_reg;

    // RULE11 wait for companion
    assign enter_trap = (trap_valid && !(trap_wait_fp && dual)) || (wait_reg && fp_done);
    assign cause_now  = wait_reg ? wait_cause_reg : trap_cause;
    assign sw_now     = trap_valid && trap_is_sw && !wait_reg;

    // RULE5 no-op reports no float trap
    assign cause_eff = last_fnop_reg ? (cause_now & ~(7'h01 << `DIT_C_FT)) : cause_now;

    dit_issue_seq u_seq
    (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .adv          (adv),
        .word_lo      (fetch_lo),
        .force_single (enter_trap),
        .mode         (mode),
        .next_other   (next_other)
    );

    // RULE5 no-op leaves pipelines alone
    assign fp_kill = dit_is_fnop(fetch_lo);
    // RULE1 high half is core
    assign core_sel = dual ? fetch_hi : fetch_lo;

    // RULE9 compare result wins
    assign cc_next = (adv && dual && fp_cmp_cc) ? fp_cmp_val :
                     (adv && core_sets_cc)      ? core_cc_val : cc_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iss_fp_valid   <= 1'b0;
            iss_fp_word    <= 32'h0000_0000;
            iss_core_valid <= 1'b0;
            iss_core_word  <= 32'h0000_0000;
            iss_dual       <= 1'b0;
            br_cc          <= 1'b0;
            fp_src_old     <= 1'b0;
            st_fwd_sel     <= 1'b0;
        end
        else
        begin
            // RULE1 pair issued together
            // RULE4 delay slot keeps both halves
            iss_fp_valid   <= adv && (dual || dit_is_fp(fetch_lo)) && !fp_kill;
            iss_fp_word    <= fetch_lo;
            iss_core_valid <= adv && (dual || !dit_is_fp(fetch_lo));
            iss_core_word  <= core_sel;
            iss_dual       <= adv && dual;
            // RULE6 branch sees old code
            br_cc          <= cc_reg;
            // RULE7 source read before load
            fp_src_old     <= adv && dual && core_fp_load;
            // RULE8 store takes companion result
            st_fwd_sel     <= adv && dual && core_fp_store && fp_pipelined
                              && (core_store_reg == fp_pipe_dest);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_addr_reg <= 32'h0000_0000;
            last_dual_reg <= 1'b0;
            last_fnop_reg <= 1'b0;
            cc_reg        <= 1'b0;
        end
        else
        begin
            cc_reg <= cc_next;
            if (adv)
            begin
                last_addr_reg <= fetch_addr;
                last_dual_reg <= dual;
                last_fnop_reg <= fp_kill;
            end
        end
    end

    // Deferred trap: cause held until the float half reports done
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_reg       <= 1'b0;
            wait_cause_reg <= 7'h00;
        end
        else if (trap_valid && trap_wait_fp && dual && !wait_reg)
        begin
            wait_reg       <= 1'b1;
            wait_cause_reg <= trap_cause;
        end
        else if (wait_reg && fp_done)
        begin
            wait_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fp_abort       <= 1'b0;
            fp_finish_req  <= 1'b0;
            insn_abort     <= 1'b0;
            redirect_valid <= 1'b0;
            redirect_pc    <= 32'h0000_0000;
        end
        else
        begin
            // RULE10 abort float half
            fp_abort       <= sw_now && dual;
            fp_finish_req  <= wait_reg && !fp_done;
            // RULE19 abort current instruction
            insn_abort     <= enter_trap;
            // RULE23 fixed handler address
            redirect_valid <= enter_trap;
            redirect_pc    <= `DIT_TRAP_VECTOR;
        end
    end

    // Software write first, trap entry on top so a coinciding event is kept
    assign psr_wr = (reg_we && reg_addr == `DIT_ADDR_STATUS) ? reg_wdata[10:0] : psr_reg;

    always_comb
    begin
        psr_next = psr_wr;
        ext_next = (reg_we && reg_addr == `DIT_ADDR_EXT) ? reg_wdata[1:0] : ext_reg;
        fir_next = fir_reg;
        if (enter_trap)
        begin
            // RULE19 save then clear modes
            psr_next[`DIT_P_PU]  = psr_reg[`DIT_P_U];
            psr_next[`DIT_P_PIM] = psr_reg[`DIT_P_IM];
            psr_next[`DIT_P_U]   = 1'b0;
            psr_next[`DIT_P_IM]  = 1'b0;
            // RULE20 paired flag
            psr_next[`DIT_P_DIM] = dual;
            // RULE21 pending switch flag
            psr_next[`DIT_P_DS]  = next_other;
            // RULE22 all occurring bits
            psr_next[`DIT_P_IT]  = psr_wr[`DIT_P_IT]  | cause_eff[`DIT_C_IT];
            psr_next[`DIT_P_IN]  = psr_wr[`DIT_P_IN]  | cause_eff[`DIT_C_IN];
            psr_next[`DIT_P_IAT] = psr_wr[`DIT_P_IAT] | cause_eff[`DIT_C_IAT];
            psr_next[`DIT_P_DAT] = psr_wr[`DIT_P_DAT] | cause_eff[`DIT_C_DAT];
            // RULE10 float flag untouched
            psr_next[`DIT_P_FT]  = psr_wr[`DIT_P_FT]  | (cause_eff[`DIT_C_FT] && !(sw_now && dual));
            ext_next[`DIT_E_IL]  = ext_next[`DIT_E_IL] | cause_eff[`DIT_C_IL];
            ext_next[`DIT_E_OF]  = ext_next[`DIT_E_OF] | cause_eff[`DIT_C_OF];
            // RULE24 float half address
            fir_next = last_dual_reg ? {last_addr_reg[31:3], 3'b000} : last_addr_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            psr_reg <= `DIT_PSR_RESET;
            ext_reg <= 2'b00;
            fir_reg <= 32'h0000_0000;
        end
        else
        begin
            psr_reg <= psr_next;
            ext_reg <= ext_next;
            fir_reg <= fir_next;
        end
    end

    assign rd_mux = (reg_addr == `DIT_ADDR_STATUS) ? {21'h000000, psr_reg} :
                    (reg_addr == `DIT_ADDR_EXT)    ? {30'h00000000, ext_reg} :
                    (reg_addr == `DIT_ADDR_FIR)    ? fir_reg :
                    (reg_addr == `DIT_ADDR_CC)     ? {31'h00000000, cc_reg} : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_re ? rd_mux : 32'h0000_0000;
    end
endmodule

// [core/dit_defines.svh]
// Function
// RULE1 - Paired issue fetches aligned pairs: low half float, high half core, issued together.
// RULE2 - Single issue meeting float instruction with dual bit: one more single, then paired.
// RULE3 - Paired issue meeting float half with dual bit clear: one more pair, then single.
// RULE4 - A pair in a delayed branch slot executes both halves.
// RULE5 - Core zero shift is float no-op: no pipeline effect, no traps, cannot start pairing.
// RULE6 - Branch on condition paired with compare tests the condition code before it.
// RULE7 - Float half reads register value from before the companion core load.
// RULE8 - Core store of companion pipelined float destination stores that companion result.
// RULE9 - Compare result wins over core half when both write the condition code.
// RULE10 - Software trap in paired issue aborts float half, float flags left unchanged.
// RULE11 - Overflow or listed instruction trap in pairs waits for float companion completion.
// RULE12 - Program aligns every float instruction with dual bit set on eight bytes.
// RULE13 - Program never starts leaving paired issue on a control transfer pair.
// RULE14 - Program pairs control register access only with the paired no-op.
// RULE15 - Program avoids indirect branch with trap bits set, and transitions after it.
// RULE16 - Program keeps core loads off the companion float destinations, except zero pair.
// RULE17 - Program starts no issue mode transition during a locked bus sequence.
// RULE18 - Program avoids equal or greater compares beside and after conditional delayed branches.
// RULE19 - Any trap aborts current instruction, saves user and interrupt bits, clears both.
// RULE20 - Trap entry sets trapped-in-paired flag when issuing pairs, clears it otherwise.
// RULE21 - Trap entry sets pending switch flag when next instruction changes issue mode.
// RULE22 - Trap entry sets every trap type bit whose condition occurred, several together.
// RULE23 - After saving state, jump to fixed handler address in single issue.
// RULE24 - Paired trap loads fault address with the float half address.
// RULE25 - Float dual bit sits at the same position as the no-op dual bit.
`ifndef DIT_DEFINES_SVH
`define DIT_DEFINES_SVH
`define DIT_DUAL_BIT     9
`define DIT_OPC_MSB      31
`define DIT_OPC_LSB      26
`define DIT_FP_OPC       6'h12
`define DIT_FNOP_WORD    32'hB000_0000
`define DIT_FNOP_MASK    32'hFFFF_FDFF
`define DIT_TRAP_VECTOR  32'h0FFF_FF00
`define DIT_ADDR_STATUS  4'h0
`define DIT_ADDR_EXT     4'h4
`define DIT_ADDR_FIR     4'h8
`define DIT_ADDR_CC      4'hC
`define DIT_PSR_RESET    11'h000
`define DIT_P_U          0
`define DIT_P_IM         1
`define DIT_P_PU         2
`define DIT_P_PIM        3
`define DIT_P_IT         4
`define DIT_P_IN         5
`define DIT_P_IAT        6
`define DIT_P_DAT        7
`define DIT_P_FT         8
`define DIT_P_DIM        9
`define DIT_P_DS         10
`define DIT_E_IL         0
`define DIT_E_OF         1
`define DIT_C_IT         0
`define DIT_C_IN         1
`define DIT_C_IAT        2
`define DIT_C_DAT        3
`define DIT_C_FT         4
`define DIT_C_IL         5
`define DIT_C_OF         6
`endif

// [core/dit_pkg.sv]
`include "dit_defines.svh"
package dit_pkg;
    typedef enum logic [1:0]
    {
        DIT_SINGLE = 2'b00,
        DIT_ENTER  = 2'b01,
        DIT_DUAL   = 2'b10,
        DIT_LEAVE  = 2'b11
    } dit_mode_t;

    function automatic logic dit_is_fnop(input logic [31:0] w);
        dit_is_fnop = ((w & `DIT_FNOP_MASK) == `DIT_FNOP_WORD);
    endfunction

    function automatic logic dit_is_fp(input logic [31:0] w);
        dit_is_fp = (w[`DIT_OPC_MSB:`DIT_OPC_LSB] == `DIT_FP_OPC);
    endfunction
endpackage

// [core/dit_issue_seq.sv]
module dit_issue_seq
    import dit_pkg::*;
(
    input  wire logic        core_clk,    // Core clock
    input  wire logic        rst_n,       // Async reset, low
    input  wire logic        adv,         // One instruction or pair issued
    input  wire logic [31:0] word_lo,     // Float half or single word
    input  wire logic        force_single,// Trap entry
    output dit_mode_t        mode,        // Current issue mode
    output logic             next_other   // Next issue uses other mode
);
    dit_mode_t mode_reg;
    dit_mode_t mode_next;
    logic      dbit;
    logic      fp_w;

    // RULE25 shared bit
    assign dbit = word_lo[`DIT_DUAL_BIT];
    // RULE5 no-op never enters
    assign fp_w = dit_is_fp(word_lo) && !dit_is_fnop(word_lo);

    always_comb
    begin
        mode_next = mode_reg;
        if (force_single)
        begin
            // RULE23 handler single issue
            mode_next = DIT_SINGLE;
        end
        else if (adv)
        begin
            unique case (mode_reg)
                // RULE2 one more single
                DIT_SINGLE: mode_next = (fp_w && dbit) ? DIT_ENTER : DIT_SINGLE;
                DIT_ENTER:  mode_next = DIT_DUAL;
                // RULE3 one more pair
                DIT_DUAL:   mode_next = dbit ? DIT_DUAL : DIT_LEAVE;
                DIT_LEAVE:  mode_next = DIT_SINGLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_reg <= DIT_SINGLE;
        else
            mode_reg <= mode_next;
    end

    assign mode = mode_reg;
    // RULE21 switch pending
    assign next_other = (mode_reg == DIT_ENTER) || (mode_reg == DIT_LEAVE);
endmodule

// [testbench/dit_top_asserts.sv]
module dit_chk
(
    input wire logic        core_clk,       // Clock
    input wire logic        rst_n,          // Reset, low
    input wire logic [31:0] fetch_lo,       // Low word
    input wire logic [31:0] fetch_hi,       // High word
    input wire logic        trap_valid,     // Trap pulse
    input wire logic        trap_wait_fp,   // Waiting trap
    input wire logic        fp_done,        // Float finished
    input wire logic [31:0] iss_fp_word,    // Float word
    input wire logic        iss_core_valid, // Core issued
    input wire logic [31:0] iss_core_word,  // Core word
    input wire logic        iss_dual,       // Pair issued
    input wire logic        fp_abort,       // Float kill
    input wire logic        fp_finish_req,  // Finish request
    input wire logic        insn_abort,     // Instr abort
    input wire logic        redirect_valid, // Handler jump
    input wire logic [31:0] redirect_pc     // Handler address
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_redir_pc; redirect_valid |-> redirect_pc == 32'h0FFF_FF00; endproperty
    a_redir_pc: assert property (p_redir_pc) else $error("bad handler address");
    property p_pulse; redirect_valid |=> !redirect_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("jump not a pulse");
    property p_trap; trap_valid && !trap_wait_fp |=> redirect_valid && insn_abort; endproperty
    a_trap: assert property (p_trap) else $error("trap entry late");
    property p_fin; fp_finish_req |=> redirect_valid == $past(fp_done); endproperty
    a_fin: assert property (p_fin) else $error("entry not tied to float done");
    property p_fin_hold; fp_finish_req && !fp_done |=> fp_finish_req; endproperty
    a_fin_hold: assert property (p_fin_hold) else $error("finish request dropped");
    property p_abort_sw; fp_abort |-> redirect_valid && insn_abort; endproperty
    a_abort_sw: assert property (p_abort_sw) else $error("stray float abort");
    property p_dual_core; iss_dual |-> iss_core_valid; endproperty
    a_dual_core: assert property (p_dual_core) else $error("pair without core half");
    property p_pair_word; iss_dual |-> iss_core_word == $past(fetch_hi) && iss_fp_word == $past(fetch_lo); endproperty
    a_pair_word: assert property (p_pair_word) else $error("pair halves swapped");
    c_dual: cover property (iss_dual);
    c_abort: cover property (fp_abort);
    c_wait: cover property (fp_finish_req && fp_done);
endmodule

// [testbench/dit_fpu_model.sv]
module dit_fpu_model
(
    input  wire logic core_clk,      // Clock
    input  wire logic rst_n,         // Reset, low
    input  wire logic fp_finish_req, // Finish request
    input  wire logic slow,          // Long latency
    output logic      fp_done        // Finished pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 4'h0;
            fp_done <= 1'h0;
        end
        else
        begin
            cnt_reg <= fp_finish_req ? cnt_reg + 4'h1 : 4'h0;
            fp_done <= fp_finish_req && (cnt_reg == (slow ? 4'h8 : 4'h2));
        end
    end
endmodule

// [testbench/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'h0, rst_n = 1'h0, fetch_valid = 1'h0, trap_valid = 1'h0, trap_is_sw = 1'h0;
    logic        trap_wait_fp = 1'h0, reg_we = 1'h0, reg_re = 1'h0, re_d = 1'h0, fpu_slow = 1'h0;
    logic        core_delayed_br = 1'h0, core_sets_cc = 1'h0, core_cc_val = 1'h0, fp_cmp_cc = 1'h0;
    logic        fp_cmp_val = 1'h0, core_fp_load = 1'h0, core_fp_store = 1'h0, fp_pipelined = 1'h0;
    logic [31:0] fetch_addr = 32'h0, fetch_lo = 32'h0, fetch_hi = 32'h0, reg_wdata = 32'h0;
    logic [4:0]  core_store_reg = 5'h0, fp_pipe_dest = 5'h0;
    logic [6:0]  trap_cause = 7'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic        fp_done, iss_fp_valid, iss_core_valid, iss_dual, br_cc, fp_src_old, st_fwd_sel;
    logic        fp_abort, fp_finish_req, insn_abort, redirect_valid;
    logic [31:0] reg_rdata, iss_fp_word, iss_core_word, redirect_pc;
    logic [69:0] q[$];
    logic [31:0] rq[$];
    logic [69:0] e;
    int          seed = 71, n_fail = 0, cmp_count = 0, k;
    dit_top i_dit_top (.*);
    dit_fpu_model i_dit_fpu_model (.core_clk, .rst_n, .fp_finish_req, .slow(fpu_slow), .fp_done);
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input logic [35:0] g, x);
        cmp_count++;
        if (g !== x)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic summarize();
        chk(36'(q.size()), 36'h0);
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Kind 0 core, 2 float, 3 float with dual bit
    function automatic logic [31:0] wd(input logic [1:0] t);
        logic [31:0] r;
        r = $random(seed);
        return t[1] ? {6'h12, r[25:10], t[0], r[8:0]} : {6'h01, r[25:0]};
    endfunction
    task automatic fetch(input logic [31:0] a, lo, hi, input logic [2:0] f, input logic [7:0] u);
        logic [4:0] r;
        r = 5'($random(seed));
        @(posedge core_clk);
        {fetch_valid, fetch_addr, fetch_lo, fetch_hi} <= {1'h1, a, lo, hi};
        {core_delayed_br, core_sets_cc, core_cc_val, fp_cmp_cc, fp_cmp_val,
            core_fp_load, core_fp_store, fp_pipelined} <= u;
        {core_store_reg, fp_pipe_dest} <= {r, r ^ {4'h0, ~u[0]}};
        q.push_back({1'h0, f, u[2] & f[0], u[1] & u[0] & f[0], lo, f[0] ? hi : lo});
    endtask
    task automatic idle();
        @(posedge core_clk);
        fetch_valid <= 1'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {reg_we, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge core_clk);
        reg_we <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        @(posedge core_clk);
        {reg_re, reg_addr} <= {1'h1, a};
        rq.push_back(x);
        @(posedge core_clk);
        reg_re <= 1'h0;
    endtask
    task automatic trap(input logic [6:0] c, input logic sw, wt, input logic [1:0] ab);
        int i;
        @(posedge core_clk);
        {fetch_valid, trap_valid, trap_cause, trap_is_sw, trap_wait_fp} <= {2'h1, c, sw, wt};
        q.push_back({1'h1, ab, 35'h0, 32'h0FFF_FF00});
        @(posedge core_clk);
        trap_valid <= 1'h0;
        for (i = 0; i < 40 && redirect_valid !== 1'h1; i++)
            @(posedge core_clk);
        repeat (2) @(posedge core_clk);
    endtask
    always @(posedge core_clk) re_d <= reg_re;
    always @(negedge core_clk)
    begin
        if (re_d === 1'h1)
            chk(reg_rdata, rq.pop_front());
        if (rst_n === 1'h1 && (iss_fp_valid === 1'h1 || iss_core_valid === 1'h1 || redirect_valid === 1'h1))
        begin
            // Empty queue yields a trap note that still matches while redirect_pc holds its reset value
            e = (q.size() > 0) ? q.pop_front() : {1'h1, 69'h0};
            if (e[69])
                chk({insn_abort, fp_abort, redirect_pc}, {e[68:67], e[31:0]});
            else
            begin
                chk({iss_fp_valid, iss_core_valid, iss_dual, fp_src_old, st_fwd_sel}, e[68:64]);
                if (e[68])
                    chk(iss_fp_word, e[63:32]);
                if (e[67])
                    chk(iss_core_word, e[31:0]);
            end
        end
    end
    initial
    begin
        #100000;
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'h1;
        fetch(32'h100, wd(0), 32'h0, 3'h2, 8'h00);
        fetch(32'h104, wd(2), 32'h0, 3'h4, 8'h00);
        fetch(32'h108, wd(3), 32'h0, 3'h4, 8'h00);
        fetch(32'h10C, wd(0), 32'h0, 3'h2, 8'h00);
        fetch(32'h110, wd(3), wd(0), 3'h7, 8'h00);
        fetch(32'h118, wd(2), wd(0), 3'h7, 8'h07);
        fetch(32'h120, wd(2), wd(0), 3'h7, 8'h00);
        fetch(32'h128, wd(0), 32'h0, 3'h2, 8'h00);
        idle();
        $display("test 1 done");
        fetch(32'h200, 32'hB000_0200, 32'h0, 3'h2, 8'h00);
        fetch(32'h204, wd(0), 32'h0, 3'h2, 8'h00);
        fetch(32'h208, wd(0), 32'h0, 3'h2, 8'h00);
        idle();
        $display("test 2 done");
        fetch(32'h300, wd(3), 32'h0, 3'h4, 8'h00);
        trap(7'h01, 1'h0, 1'h0, 2'h2);
        rd(4'h0, 32'h410);
        wr(4'h0, 32'h0);
        fetch(32'h300, wd(3), 32'h0, 3'h4, 8'h00);
        fetch(32'h304, wd(0), 32'h0, 3'h2, 8'h00);
        fetch(32'h308, wd(3), wd(0), 3'h7, 8'h80);
        fetch(32'h310, wd(3), wd(0), 3'h7, 8'h58);
        trap(7'h11, 1'h1, 1'h0, 2'h3);
        rd(4'h0, 32'h210);
        rd(4'h8, 32'h310);
        rd(4'hC, 32'h1);
        $display("test 3 done");
        for (k = 0; k < 2; k++)
        begin
            wr(4'h0, 32'h0);
            fpu_slow <= k[0];
            fetch(32'h400, wd(3), 32'h0, 3'h4, 8'h00);
            fetch(32'h404, wd(0), 32'h0, 3'h2, 8'h00);
            fetch(32'h408, wd(3), wd(0), 3'h7, 8'h00);
            trap(7'h40, 1'h0, 1'h1, 2'h2);
            rd(4'h0, 32'h200);
            rd(4'h4, 32'h2);
        end
        $display("test 4 done");
        wr(4'h0, 32'h3);
        trap(7'h65, 1'h0, 1'h0, 2'h2);
        rd(4'h0, 32'h5C);
        rd(4'h4, 32'h3);
        wr(4'hC, 32'h0);
        rd(4'hC, 32'h1);
        rd(4'h2, 32'h0);
        $display("test 5 done");
        summarize();
    end
endmodule
bind dit_top dit_chk i_dit_chk (.core_clk, .rst_n, .fetch_lo, .fetch_hi, .trap_valid, .trap_wait_fp, .fp_done,
    .iss_fp_word, .iss_core_valid, .iss_core_word, .iss_dual, .fp_abort, .fp_finish_req, .insn_abort,
    .redirect_valid, .redirect_pc);
